// ===== verilog/frpc_pkg.sv
// package for the flash row erase/program controller
// assumes one 100 MHz clock domain shared with the register port
package frpc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [3:0]  ADDR_CONTROL   = 4'h0;
	localparam logic [3:0]  ADDR_KEY       = 4'h2;
	localparam logic [3:0]  ADDR_PAGE      = 4'h4;
	localparam logic [3:0]  ADDR_OFFSET    = 4'h6;
	localparam logic [15:0] CONTROL_RESET  = 16'h0000;
	localparam logic [15:0] CONTROL_WMASK  = 16'h707F;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int START_POS   = 15;
	localparam int PERMIT_POS  = 14;
	localparam int FAULT_POS   = 13;
	localparam int PROGRAM_ONLY_SELECT_POS = 12;
	localparam int ERASE_POS   = 6;

	// ------------------------------------------------------------
	// keys and operation codes
	// ------------------------------------------------------------
	localparam logic [7:0] KEY_FIRST  = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'hAA;
	localparam logic [5:0] OP_ERASE_4 = 6'h1A;
	localparam logic [5:0] OP_ERASE_2 = 6'h19;
	localparam logic [5:0] OP_ERASE_1 = 6'h18;
	localparam logic [3:0] OP_BOOT    = 4'hA;
	localparam logic [3:0] OP_ALL     = 4'h9;
	localparam logic [3:0] OP_CONFIG  = 4'h5;
	localparam logic [3:0] OP_EEPROM  = 4'h4;
	localparam logic [3:0] OP_GENERAL = 4'h3;
	localparam logic [3:0] OP_ROW_PGM = 4'h1;

	// array action handed to the flash array
	localparam logic [3:0] ACT_NONE    = 4'h0;
	localparam logic [3:0] ACT_ERASE_1 = 4'h1;
	localparam logic [3:0] ACT_ERASE_2 = 4'h2;
	localparam logic [3:0] ACT_ERASE_4 = 4'h3;
	localparam logic [3:0] ACT_BOOT    = 4'h4;
	localparam logic [3:0] ACT_ALL     = 4'h5;
	localparam logic [3:0] ACT_CONFIG  = 4'h6;
	localparam logic [3:0] ACT_EEPROM  = 4'h7;
	localparam logic [3:0] ACT_GENERAL = 4'h8;
	localparam logic [3:0] ACT_PROGRAM = 4'h9;

	// ------------------------------------------------------------
	// row geometry and timing
	// ------------------------------------------------------------
	localparam int ROW_WORDS     = 32;
	localparam int CLK_PERIOD_NS = 10;
	localparam int OP_TIME_NS    = 2000;
	localparam int OP_CYCLES     = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		FRPC_IDLE  = 3'b001,
		FRPC_KEY1  = 3'b010,
		FRPC_OPEN  = 3'b100
	} frpc_key_e;

	typedef enum logic [1:0] {
		FRPC_READY = 2'b01,
		FRPC_BUSY  = 2'b10
	} frpc_op_e;

endpackage : frpc_pkg

// ===== verilog/frpc_ctrl.sv
// flash row erase/program sequencer with key unlock
// assumes the flash array pulses done_in when a launched action ends
`timescale 1ns/10ps

module frpc_ctrl
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	// register port
	input  wire logic [3:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out,
	// mode and array
	input  wire logic        serial_mode_in,
	input  wire logic        done_in,
	output logic             stall_out,
	output logic             array_go_out,
	output logic      [3:0]  array_act_out,
	output logic      [23:0] array_addr_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0]          ctrl;
		logic [7:0]           page;
		logic [15:0]          offs;
		frpc_pkg::frpc_key_e  key;
		frpc_pkg::frpc_op_e   op;
		logic [15:0]          rdata;
		logic                 stall;
		logic                 go;
		logic [3:0]           act;
		logic [23:0]          addr;
	} frpc_state_s;

	frpc_state_s st_q;
	frpc_state_s st_d;

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	function automatic logic [3:0] frpc_decode(input logic erase, input logic [5:0] code,
		input logic serial);
		logic [3:0] act;
		act = frpc_pkg::ACT_NONE;
		if (erase)
		begin
			if (code == frpc_pkg::OP_ERASE_4)
				act = frpc_pkg::ACT_ERASE_4;
			else if (code == frpc_pkg::OP_ERASE_2)
				act = frpc_pkg::ACT_ERASE_2;
			else if (code == frpc_pkg::OP_ERASE_1)
				act = frpc_pkg::ACT_ERASE_1;
			else if (code[5:2] == frpc_pkg::OP_BOOT && serial)
				act = frpc_pkg::ACT_BOOT;
			else if (code[5:2] == frpc_pkg::OP_ALL && serial)
				act = frpc_pkg::ACT_ALL;
			else if (code[5:2] == frpc_pkg::OP_CONFIG)
				act = frpc_pkg::ACT_CONFIG;
			else if (code[5:2] == frpc_pkg::OP_EEPROM)
				act = frpc_pkg::ACT_EEPROM;
			else if (code[5:2] == frpc_pkg::OP_GENERAL)
				act = frpc_pkg::ACT_GENERAL;
		end
		else if (code[5:2] == frpc_pkg::OP_ROW_PGM)
			act = frpc_pkg::ACT_PROGRAM;
		return act;
	endfunction : frpc_decode

	logic [3:0]  act_w;
	logic        ctrl_wr;
	logic        key_wr;
	logic        start_req;
	logic        unlocked;
	logic [23:0] row_base;
	logic        start_ok;
	logic        erase_ok;
	logic        prog_ok;

	always_comb
	begin
		ctrl_wr   = wr_in && addr_in == frpc_pkg::ADDR_CONTROL;
		key_wr    = wr_in && addr_in == frpc_pkg::ADDR_KEY;
		unlocked  = st_q.key == frpc_pkg::FRPC_OPEN;
		start_req = ctrl_wr && wdata_in[frpc_pkg::START_POS]
			&& st_q.op == frpc_pkg::FRPC_READY;
		act_w     = frpc_decode(wdata_in[frpc_pkg::ERASE_POS], wdata_in[5:0], serial_mode_in);
		start_ok  = start_req && unlocked && wdata_in[frpc_pkg::PERMIT_POS];
		erase_ok  = start_ok && wdata_in[frpc_pkg::ERASE_POS];
		prog_ok   = start_ok && !wdata_in[frpc_pkg::ERASE_POS];
		// row aligned pointer; low 6 bits are word in row (2 address units per word)
		row_base  = {st_q.page, st_q.offs[15:6], 6'h00};
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		st_d      = st_q;
		st_d.go   = 1'b0;
		st_d.rdata = 16'h0000;

		// unlock sequence tracking
		case (st_q.key)
			frpc_pkg::FRPC_IDLE:
				if (key_wr && wdata_in[7:0] == frpc_pkg::KEY_FIRST)
					st_d.key = frpc_pkg::FRPC_KEY1;
			frpc_pkg::FRPC_KEY1:
				if (key_wr && wdata_in[7:0] == frpc_pkg::KEY_SECOND)
					st_d.key = frpc_pkg::FRPC_OPEN;
				else if (wr_in || rd_in)
					st_d.key = frpc_pkg::FRPC_IDLE;
			frpc_pkg::FRPC_OPEN:
				st_d.key = frpc_pkg::FRPC_IDLE;
			default:
				st_d.key = frpc_pkg::FRPC_IDLE;
		endcase

		if (wr_in && addr_in == frpc_pkg::ADDR_PAGE)
			st_d.page = wdata_in[7:0];
		if (wr_in && addr_in == frpc_pkg::ADDR_OFFSET)
			st_d.offs = wdata_in;

		// control writes only while ready: plain fields, start only when set
		if (ctrl_wr && st_q.op == frpc_pkg::FRPC_READY)
		begin
			st_d.ctrl = (st_q.ctrl & ~frpc_pkg::CONTROL_WMASK)
				| (wdata_in & frpc_pkg::CONTROL_WMASK);
			if (start_req)
			begin
				if (unlocked && wdata_in[frpc_pkg::PERMIT_POS]
					&& act_w != frpc_pkg::ACT_NONE)
				begin
					st_d.ctrl[frpc_pkg::START_POS] = 1'b1;
					st_d.ctrl[frpc_pkg::FAULT_POS] = 1'b0;
					st_d.op    = frpc_pkg::FRPC_BUSY;
					st_d.stall = 1'b1;
					st_d.go    = 1'b1;
					st_d.act   = act_w;
					st_d.addr  = row_base;
				end
				else if (!unlocked || !wdata_in[frpc_pkg::PERMIT_POS])
					st_d.ctrl[frpc_pkg::FAULT_POS] = 1'b1;
			end
		end

		case (st_q.op)
			frpc_pkg::FRPC_READY:
				st_d.stall = st_d.stall;
			frpc_pkg::FRPC_BUSY:
				if (done_in)
				begin
					st_d.ctrl[frpc_pkg::START_POS] = 1'b0;
					st_d.op    = frpc_pkg::FRPC_READY;
					st_d.stall = 1'b0;
					st_d.act   = frpc_pkg::ACT_NONE;
				end
			default:
				st_d.op = frpc_pkg::FRPC_READY;
		endcase

		if (rd_in && addr_in == frpc_pkg::ADDR_CONTROL)
			st_d.rdata = st_q.ctrl & {1'b1, frpc_pkg::CONTROL_WMASK[14:0]};
		else if (rd_in && addr_in == frpc_pkg::ADDR_PAGE)
			st_d.rdata = {8'h00, st_q.page};
		else if (rd_in && addr_in == frpc_pkg::ADDR_OFFSET)
			st_d.rdata = st_q.offs;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			st_q.ctrl  <= frpc_pkg::CONTROL_RESET;
			st_q.page  <= 8'h00;
			st_q.offs  <= 16'h0000;
			st_q.key   <= frpc_pkg::FRPC_IDLE;
			st_q.op    <= frpc_pkg::FRPC_READY;
			st_q.rdata <= 16'h0000;
			st_q.stall <= 1'b0;
			st_q.go    <= 1'b0;
			st_q.act   <= frpc_pkg::ACT_NONE;
			st_q.addr  <= 24'h000000;
		end
		else
			st_q <= st_d;
	end

	assign rdata_out      = st_q.rdata;
	assign stall_out      = st_q.stall;
	assign array_go_out   = st_q.go;
	assign array_act_out  = st_q.act;
	assign array_addr_out = st_q.addr;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	chk_start_needs_key: assert property (@(posedge clk_in) disable iff (srst_in)
		$rose(st_q.ctrl[frpc_pkg::START_POS]) |-> $past(st_q.key) == frpc_pkg::FRPC_OPEN)
		else $error("start without unlock");

	chk_start_needs_permit: assert property (@(posedge clk_in) disable iff (srst_in)
		$rose(st_q.ctrl[frpc_pkg::START_POS]) |-> st_q.ctrl[frpc_pkg::PERMIT_POS])
		else $error("start without permit");

	chk_start_launches: assert property (@(posedge clk_in) disable iff (srst_in)
		$rose(st_q.ctrl[frpc_pkg::START_POS]) |-> st_q.go && st_q.act != frpc_pkg::ACT_NONE)
		else $error("start did not launch array");

	chk_done_clears: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.op == frpc_pkg::FRPC_BUSY && done_in |=> !st_q.ctrl[frpc_pkg::START_POS])
		else $error("start not cleared at done");

	chk_zero_no_clear: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.ctrl[frpc_pkg::START_POS] && !done_in |=> st_q.ctrl[frpc_pkg::START_POS])
		else $error("start cleared by software");

	chk_stall_busy: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.stall == st_q.ctrl[frpc_pkg::START_POS])
		else $error("stall not matching busy");

	chk_fault_bad_start: assert property (@(posedge clk_in) disable iff (srst_in)
		start_req && !unlocked |=> st_q.ctrl[frpc_pkg::FAULT_POS])
		else $error("fault flag not set");

	chk_key_lost: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.key == frpc_pkg::FRPC_KEY1 && rd_in |=> st_q.key == frpc_pkg::FRPC_IDLE)
		else $error("unlock kept after stray access");

	chk_bits_zero: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.rdata[11:7] == 5'h00)
		else $error("unimplemented bits nonzero");

	chk_serial_only: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.go && (st_q.act == frpc_pkg::ACT_BOOT || st_q.act == frpc_pkg::ACT_ALL)
		|-> $past(serial_mode_in))
		else $error("serial-only erase outside serial mode");

	chk_key_lost_write: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.key == frpc_pkg::FRPC_KEY1 && wr_in && !key_wr
		|=> st_q.key == frpc_pkg::FRPC_IDLE)
		else $error("unlock kept after stray write");

	chk_open_one_cycle: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.key == frpc_pkg::FRPC_OPEN |=> st_q.key == frpc_pkg::FRPC_IDLE)
		else $error("unlock window longer than one cycle");

	chk_open_after_first: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.key == frpc_pkg::FRPC_OPEN |-> $past(st_q.key) == frpc_pkg::FRPC_KEY1)
		else $error("unlock reached without first key");

	chk_fault_no_permit: assert property (@(posedge clk_in) disable iff (srst_in)
		start_req && !wdata_in[frpc_pkg::PERMIT_POS] |=> st_q.ctrl[frpc_pkg::FAULT_POS])
		else $error("fault flag not set without permit");

	chk_fault_normal_end: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.op == frpc_pkg::FRPC_BUSY && done_in |=> !st_q.ctrl[frpc_pkg::FAULT_POS])
		else $error("fault flag set after normal end");

	chk_undefined_idle: assert property (@(posedge clk_in) disable iff (srst_in)
		start_ok && act_w == frpc_pkg::ACT_NONE
		|=> !st_q.go && !st_q.ctrl[frpc_pkg::START_POS])
		else $error("undefined code started an action");

	chk_erase_one_row: assert property (@(posedge clk_in) disable iff (srst_in)
		erase_ok && wdata_in[5:0] == frpc_pkg::OP_ERASE_1 |=> st_q.act == frpc_pkg::ACT_ERASE_1)
		else $error("one-row erase not launched");

	chk_erase_two_rows: assert property (@(posedge clk_in) disable iff (srst_in)
		erase_ok && wdata_in[5:0] == frpc_pkg::OP_ERASE_2 |=> st_q.act == frpc_pkg::ACT_ERASE_2)
		else $error("two-row erase not launched");

	chk_erase_four_rows: assert property (@(posedge clk_in) disable iff (srst_in)
		erase_ok && wdata_in[5:0] == frpc_pkg::OP_ERASE_4 |=> st_q.act == frpc_pkg::ACT_ERASE_4)
		else $error("four-row erase not launched");

	chk_config_erase: assert property (@(posedge clk_in) disable iff (srst_in)
		erase_ok && wdata_in[5:2] == frpc_pkg::OP_CONFIG |=> st_q.act == frpc_pkg::ACT_CONFIG)
		else $error("config block erase not launched");

	chk_eeprom_erase: assert property (@(posedge clk_in) disable iff (srst_in)
		erase_ok && wdata_in[5:2] == frpc_pkg::OP_EEPROM |=> st_q.act == frpc_pkg::ACT_EEPROM)
		else $error("eeprom erase not launched");

	chk_general_erase: assert property (@(posedge clk_in) disable iff (srst_in)
		erase_ok && wdata_in[5:2] == frpc_pkg::OP_GENERAL |=> st_q.act == frpc_pkg::ACT_GENERAL)
		else $error("general block erase not launched");

	chk_program_row: assert property (@(posedge clk_in) disable iff (srst_in)
		prog_ok && wdata_in[5:2] == frpc_pkg::OP_ROW_PGM |=> st_q.act == frpc_pkg::ACT_PROGRAM)
		else $error("row program not launched");

	chk_program_not_erase: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.go && st_q.act == frpc_pkg::ACT_PROGRAM |-> !st_q.ctrl[frpc_pkg::ERASE_POS])
		else $error("program launched with erase selected");

	chk_program_only_select_ignored: assert property (@(posedge clk_in) disable iff (srst_in)
		prog_ok && wdata_in[5:2] == frpc_pkg::OP_ROW_PGM && wdata_in[frpc_pkg::PROGRAM_ONLY_SELECT_POS]
		|=> st_q.go && st_q.act == frpc_pkg::ACT_PROGRAM)
		else $error("program-only bit changed flash program");

	chk_row_pointer: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.go |-> st_q.addr == {st_q.page, st_q.offs[15:6], 6'h00})
		else $error("row address not from table pointer");

	chk_act_held: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.op == frpc_pkg::FRPC_BUSY && !done_in
		|=> $stable(st_q.act) && $stable(st_q.addr))
		else $error("action changed while busy");

	chk_stall_release: assert property (@(posedge clk_in) disable iff (srst_in)
		st_q.op == frpc_pkg::FRPC_BUSY && done_in |=> !st_q.stall)
		else $error("stall kept after done");

	chk_reset_idle: assert property (@(posedge clk_in) disable iff (srst_in)
		$past(srst_in) |-> st_q.ctrl == frpc_pkg::CONTROL_RESET && !st_q.stall && !st_q.go)
		else $error("control not idle after reset");

endmodule : frpc_ctrl

// ===== dv/frpc_array_model.sv
// flash array stand-in: ends each launched action after a set delay
// assumes go_in is a one-cycle launch pulse in the clk_in domain
// also counts row latch loads since the last launch
`timescale 1ns/10ps

module frpc_array_model
(
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       srst_in,
	// launch and timing
	input  wire logic       go_in,
	input  wire logic [7:0] dly_in,
	output logic            done_out,
	// row latches
	input  wire logic       ld_in,
	output logic      [5:0] fill_out
);
	typedef struct packed
	{
		logic [7:0] cnt;
		logic [5:0] fill;
	} frpc_am_s;

	frpc_am_s st_q;
	frpc_am_s st_d;

	// ------------------------------------------------------------
	// self-timed countdown and row latch count
	// ------------------------------------------------------------
	always_comb
	begin
		st_d = st_q;
		if (go_in)
			st_d.cnt = dly_in;
		else if (st_q.cnt != 8'h00)
			st_d.cnt = st_q.cnt - 8'h01;
		if (go_in)
			st_d.fill = 6'h00;
		else if (ld_in && st_q.fill != 6'h20)
			st_d.fill = st_q.fill + 6'h01;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign done_out = (st_q.cnt == 8'h01);
	assign fill_out = st_q.fill;
endmodule : frpc_array_model

// ===== dv/testbench.sv
// self-checking bench for the flash sequencer over its register port
// assumes frpc_pkg and frpc_ctrl are compiled first
`timescale 1ns/10ps

module testbench;
	logic        clk_in  = 1'b0;
	logic        srst_in = 1'b1;
	logic [3:0]  addr    = 4'h0;
	logic [15:0] wdata   = 16'h0000;
	logic        wr      = 1'b0;
	logic        rd      = 1'b0;
	logic        ser     = 1'b0;
	logic [7:0]  dly     = 8'h01;
	logic        ld      = 1'b0;
	logic [5:0]  fill;
	logic        done;
	logic        stall;
	logic        go;
	logic [15:0] rdata;
	logic [3:0]  act;
	logic [23:0] aaddr;
	int          n_mismatch = 0;
	int          checks     = 0;
	int          n;
	logic [15:0] tc [11] = '{16'hC05A, 16'hC059, 16'hC058, 16'hC054, 16'hC050, 16'hC04C,
		16'hC004, 16'hD004, 16'hC068, 16'hC064, 16'hC07F};
	logic        ts [11] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
	logic [3:0]  ta [11] = '{4'h3, 4'h2, 4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'h9, 4'h4, 4'h5, 4'h0};

	always #5 clk_in = ~clk_in;

	frpc_ctrl DUT (.clk_in(clk_in), .srst_in(srst_in), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .serial_mode_in(ser), .done_in(done),
		.stall_out(stall), .array_go_out(go), .array_act_out(act), .array_addr_out(aaddr));

	frpc_array_model u_arr (.clk_in(clk_in), .srst_in(srst_in), .go_in(go), .dly_in(dly),
		.done_out(done), .ld_in(ld), .fill_out(fill));

	// ------------------------------------------------------------
	// bus tasks and checks
	// ------------------------------------------------------------
	task automatic test_done;
		if (n_mismatch == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	task automatic cmp(input string nm, input logic [23:0] e, input logic [23:0] g,
		input logic [23:0] m);
		checks++;
		if ((g & m) !== (e & m))
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	task automatic wr_t(input logic [3:0] a, input logic [15:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		rd    <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask : wr_t

	task automatic rd_t(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
		addr <= a;
		rd   <= 1'b1;
		wr   <= 1'b0;
		@(posedge clk_in);
		#1;
		cmp("rdata", 24'(e), 24'(rdata), 24'(m));
	endtask : rd_t

	task automatic idle;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge clk_in);
		#1;
	endtask : idle

	task automatic keys;
		wr_t(frpc_pkg::ADDR_KEY, 16'h0055);
		wr_t(frpc_pkg::ADDR_KEY, 16'h00AA);
	endtask : keys

	task automatic load_row;
		repeat (frpc_pkg::ROW_WORDS)
		begin
			ld <= 1'b1;
			@(posedge clk_in);
			#1;
		end
		ld <= 1'b0;
		cmp("fill", 24'(frpc_pkg::ROW_WORDS), 24'(fill), 24'h00003F);
	endtask : load_row

	task automatic wait_done;
		n = 0;
		while (stall !== 1'b0)
		begin
			if (n == 200)
			begin
				n_mismatch++;
				test_done;
			end
			@(posedge clk_in);
			#1;
			n++;
		end
	endtask : wait_done

	// unlock if asked, write control, check launch, wait, read back
	task automatic run_op(input logic [15:0] c, input logic s, input logic unl,
		input logic [3:0] a);
		logic ok;
		logic st;
		ok  = unl & c[frpc_pkg::PERMIT_POS];
		st  = (a != frpc_pkg::ACT_NONE);
		ser <= s;
		if (unl)
			keys;
		wr_t(frpc_pkg::ADDR_CONTROL, c);
		cmp("go", 24'(st), 24'(go), 24'h1);
		cmp("stall", 24'(st), 24'(stall), 24'h1);
		cmp("act", 24'(a), 24'(act), 24'hF);
		if (st)
			cmp("row", 24'h126A40, aaddr, 24'hFFFFFF);
		idle;
		idle;
		wait_done;
		if (st)
			cmp("held", 24'(dly), 24'(n + 1), 24'hFFFFFF);
		if (ok)
			rd_t(frpc_pkg::ADDR_CONTROL, c & 16'h507F, 16'hFFFF);
		else
			rd_t(frpc_pkg::ADDR_CONTROL, 16'h2000, 16'hA000);
	endtask : run_op

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge clk_in);
		#1;
		srst_in <= 1'b0;
		@(posedge clk_in);
		#1;
		cmp("stall", 24'h0, 24'(stall), 24'h1);
		rd_t(frpc_pkg::ADDR_CONTROL, 16'h0000, 16'hFFFF);
		rd_t(4'hE, 16'h0000, 16'hFFFF);
		wr_t(frpc_pkg::ADDR_PAGE, 16'h0012);
		wr_t(frpc_pkg::ADDR_OFFSET, 16'h6A7F);
		wr_t(frpc_pkg::ADDR_CONTROL, 16'h0F80);
		rd_t(frpc_pkg::ADDR_CONTROL, 16'h0000, 16'hFFFF);
		run_op(16'h8058, 1'b0, 1'b1, frpc_pkg::ACT_NONE);
		run_op(16'hC058, 1'b0, 1'b0, frpc_pkg::ACT_NONE);
		wr_t(frpc_pkg::ADDR_KEY, 16'h0055);
		rd_t(frpc_pkg::ADDR_KEY, 16'h0000, 16'hFFFF);
		wr_t(frpc_pkg::ADDR_KEY, 16'h00AA);
		run_op(16'hC058, 1'b0, 1'b0, frpc_pkg::ACT_NONE);
		keys;
		idle;
		run_op(16'hC058, 1'b0, 1'b0, frpc_pkg::ACT_NONE);
		run_op(16'hC068, 1'b0, 1'b1, frpc_pkg::ACT_NONE);
		for (int i = 0; i < 11; i++)
		begin
			dly <= (i == 0) ? 8'h28 : 8'h02;
			if (ta[i] == frpc_pkg::ACT_PROGRAM)
				load_row;
			run_op(tc[i], ts[i], 1'b1, ta[i]);
		end
		dly <= 8'h28;
		keys;
		wr_t(frpc_pkg::ADDR_CONTROL, 16'hC058);
		wr_t(frpc_pkg::ADDR_CONTROL, 16'h0000);
		rd_t(frpc_pkg::ADDR_CONTROL, 16'h8000, 16'h8000);
		idle;
		wait_done;
		rd_t(frpc_pkg::ADDR_CONTROL, 16'h0000, 16'hA000);
		idle;
		test_done;
	end
endmodule : testbench
